// ### shared/irq_gate_pkg.sv
package irq_gate_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int PIPES = 7;
   localparam int EVENTS = 2;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] NOTREADY_EN_OFFSET = 8'h48;
   localparam logic [7:0] EMPTY_ERR_EN_OFFSET = 8'h4C;
   localparam logic [7:0] MAIN_IRQ_STATUS_OFFSET = 8'h60;
   localparam logic [7:0] EVENT_STATUS_OFFSET = 8'h80;
   localparam logic [7:0] EVENT_MASK_OFFSET = 8'h84;
   localparam logic [7:0] GATED_VIEW_OFFSET = 8'h88;

   // ==========================================================
   // field positions
   localparam int ENABLE_MSB = 6;
   localparam int NOTREADY_FLAG_BIT = 9;
   localparam int EMPTY_FLAG_BIT = 10;
   localparam int EVT_NOTREADY_BIT = 0;
   localparam int EVT_EMPTY_BIT = 1;
   localparam int GATED_EMPTY_LSB = 8;

   // ==========================================================
   // reset values
   localparam logic [6:0] ENABLE_RESET = 7'h00;
   localparam logic [1:0] EVENT_RESET = 2'h0;
   localparam logic [15:0] RDATA_RESET = 16'h0000;

   // ==========================================================
   // timing: flag follows status and enable after this many cycles
   localparam int FLAG_LATENCY_CYCLES = 1;

   // zero-extend a seven-bit field into a bus word
   function automatic logic [15:0] widen7(input logic [6:0] v);
      widen7 = {9'h000, v};
   endfunction : widen7

endpackage : irq_gate_pkg

// ### shared/gate_if.sv
`timescale 1ns/1ns
`default_nettype none
interface gate_if;
   logic wr_en;
   logic [6:0] wdata;
   logic [6:0] status;
   logic [6:0] enable;
   logic [6:0] gated;
   logic flag;

   modport gate (
      input wr_en,
      input wdata,
      input status,
      output enable,
      output gated,
      output flag
   );

   modport user (
      output wr_en,
      output wdata,
      output status,
      input enable,
      input gated,
      input flag
   );
endinterface : gate_if
`default_nettype wire

// ### logic/enable_gate.sv
`timescale 1ns/1ns
`default_nettype none
module enable_gate
   import irq_gate_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic soft_reset,
   gate_if.gate g
);

   logic [6:0] enable_r;
   logic [6:0] enable_nxt;
   logic flag_r;
   logic flag_nxt;
   wire logic [6:0] gated_now;

   // ==========================================================
   // enable register
   // only the seven pipe bits are stored, so reserved bits read back zero
   assign enable_nxt = soft_reset ? ENABLE_RESET : (g.wr_en ? g.wdata : enable_r);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         enable_r <= ENABLE_RESET;
      end else if (ce) begin
         enable_r <= enable_nxt;
      end
   end

   // ==========================================================
   // summary flag
   // bit 0 is the control pipe, bits 1..6 the numbered pipes
   assign gated_now = g.status & enable_r;
   assign flag_nxt = |gated_now;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_r <= 1'b0;
      end else if (ce) begin
         flag_r <= flag_nxt;
      end
   end

   assign g.enable = enable_r;
   assign g.gated = gated_now;
   assign g.flag = flag_r;

endmodule : enable_gate
`default_nettype wire

// ### logic/pipe_buffer_irq_enable_gate.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module pipe_buffer_irq_enable_gate
   import irq_gate_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic SOFT_RESET,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire logic [6:0] PIPE_NOTREADY_STATUS,
   input wire logic [6:0] PIPE_EMPTY_ERR_STATUS,
   output logic SUMMARY_NOTREADY_FLAG,
   output logic SUMMARY_EMPTY_FLAG,
   output logic IRQ
);

   // ==========================================================
   // carriers to the two gates
   gate_if notready_if ();
   gate_if empty_if ();

   // ==========================================================
   // address decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   wire logic sel_notready_en;
   wire logic sel_empty_en;
   wire logic sel_main_status;
   wire logic sel_event_status;
   wire logic sel_event_mask;
   wire logic sel_gated_view;
   wire logic sel_none;

   assign sel_notready_en = hit(ADDR, NOTREADY_EN_OFFSET);
   assign sel_empty_en = hit(ADDR, EMPTY_ERR_EN_OFFSET);
   assign sel_main_status = hit(ADDR, MAIN_IRQ_STATUS_OFFSET);
   assign sel_event_status = hit(ADDR, EVENT_STATUS_OFFSET);
   assign sel_event_mask = hit(ADDR, EVENT_MASK_OFFSET);
   assign sel_gated_view = hit(ADDR, GATED_VIEW_OFFSET);
   assign sel_none = ~(sel_notready_en | sel_empty_en | sel_main_status |
                       sel_event_status | sel_event_mask | sel_gated_view);

   // ==========================================================
   // enable registers live in the gates
   // upper bits of the write are dropped; software is expected to write zero there
   assign notready_if.wr_en = WR & sel_notready_en;
   assign notready_if.wdata = WDATA[ENABLE_MSB:0];
   assign notready_if.status = PIPE_NOTREADY_STATUS;

   assign empty_if.wr_en = WR & sel_empty_en;
   assign empty_if.wdata = WDATA[ENABLE_MSB:0];
   assign empty_if.status = PIPE_EMPTY_ERR_STATUS;

   enable_gate notready_gate (
      .clk(CLK),
      .rst_b(RST_B),
      .ce(CE),
      .soft_reset(SOFT_RESET),
      .g(notready_if)
   );

   enable_gate empty_gate (
      .clk(CLK),
      .rst_b(RST_B),
      .ce(CE),
      .soft_reset(SOFT_RESET),
      .g(empty_if)
   );

   wire logic notready_flag;
   wire logic empty_flag;

   assign notready_flag = notready_if.flag;
   assign empty_flag = empty_if.flag;

   // ==========================================================
   // main status word: read-only view of the two summary flags
   // writes to this offset fall through to nothing
   wire logic [15:0] main_status_word;

   assign main_status_word = (16'(notready_flag) << NOTREADY_FLAG_BIT) |
                             (16'(empty_flag) << EMPTY_FLAG_BIT);

   // ==========================================================
   // gated view: which pipes are currently driving each flag
   wire logic [15:0] gated_word;

   assign gated_word = widen7(notready_if.gated) | (widen7(empty_if.gated) << GATED_EMPTY_LSB);

   // ==========================================================
   // event capture: a rising summary flag sets a sticky bit
   logic notready_prev_r;
   logic empty_prev_r;
   wire logic [1:0] event_set;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         notready_prev_r <= 1'b0;
         empty_prev_r <= 1'b0;
      end else if (CE) begin
         notready_prev_r <= notready_flag;
         empty_prev_r <= empty_flag;
      end
   end

   assign event_set[EVT_NOTREADY_BIT] = notready_flag & ~notready_prev_r;
   assign event_set[EVT_EMPTY_BIT] = empty_flag & ~empty_prev_r;

   // ==========================================================
   // sticky status, write one to clear
   // set beats clear so an edge landing on the clearing write is kept
   logic [1:0] event_status_r;
   logic [1:0] event_status_nxt;
   wire logic [1:0] event_clear;

   assign event_clear = (WR & sel_event_status) ? WDATA[1:0] : 2'h0;
   assign event_status_nxt = SOFT_RESET ? EVENT_RESET : ((event_status_r & ~event_clear) | event_set);

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         event_status_r <= EVENT_RESET;
      end else if (CE) begin
         event_status_r <= event_status_nxt;
      end
   end

   // ==========================================================
   // mask register, one bit per event
   logic [1:0] event_mask_r;
   logic [1:0] event_mask_nxt;

   assign event_mask_nxt = SOFT_RESET ? EVENT_RESET : ((WR & sel_event_mask) ? WDATA[1:0] : event_mask_r);

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         event_mask_r <= EVENT_RESET;
      end else if (CE) begin
         event_mask_r <= event_mask_nxt;
      end
   end

   // ==========================================================
   // interrupt line
   // registered so it never glitches while the mask is rewritten
   logic irq_r;
   wire logic irq_nxt;

   assign irq_nxt = |(event_status_nxt & event_mask_nxt);

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         irq_r <= 1'b0;
      end else if (CE) begin
         irq_r <= irq_nxt;
      end
   end

   // ==========================================================
   // read path
   // data stand only in the cycle after the strobe, zero otherwise
   wire logic [15:0] read_mux;
   logic [15:0] rdata_r;
   wire logic [15:0] rdata_nxt;

   assign read_mux = sel_notready_en ? widen7(notready_if.enable) :
                     sel_empty_en ? widen7(empty_if.enable) :
                     sel_main_status ? main_status_word :
                     sel_event_status ? {14'h0000, event_status_r} :
                     sel_event_mask ? {14'h0000, event_mask_r} :
                     sel_gated_view ? gated_word :
                     RDATA_RESET;

   assign rdata_nxt = (RD & ~sel_none) ? read_mux : RDATA_RESET;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rdata_r <= RDATA_RESET;
      end else if (CE) begin
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign RDATA = rdata_r;
   assign SUMMARY_NOTREADY_FLAG = notready_flag;
   assign SUMMARY_EMPTY_FLAG = empty_flag;
   assign IRQ = irq_r;

endmodule : pipe_buffer_irq_enable_gate
`default_nettype wire

// ### testbench/gate_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module gate_monitor
   import irq_gate_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic SOFT_RESET,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   input wire logic [6:0] PIPE_NOTREADY_STATUS,
   input wire logic [6:0] PIPE_EMPTY_ERR_STATUS,
   input wire logic SUMMARY_NOTREADY_FLAG,
   input wire logic SUMMARY_EMPTY_FLAG,
   input wire logic IRQ
);
   // ==========
   // shadow enables, so reads and flags can be tied to the writes
   logic [6:0] nr_r;
   logic [6:0] em_r;
   wire hit_map = ADDR inside {8'h48, 8'h4C, 8'h60, 8'h80, 8'h84, 8'h88};
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         nr_r <= 7'h00;
         em_r <= 7'h00;
      end else if (CE && SOFT_RESET) begin
         nr_r <= 7'h00;
         em_r <= 7'h00;
      end else if (CE && WR) begin
         if (ADDR == NOTREADY_EN_OFFSET) nr_r <= WDATA[6:0];
         if (ADDR == EMPTY_ERR_EN_OFFSET) em_r <= WDATA[6:0];
      end
   end
   // ==========
   // properties
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   property p_rd_idle; CE && !RD |=> RDATA == 16'h0000; endproperty
   property p_rd_nr; CE && RD && ADDR == 8'h48 |=> RDATA == {9'h000, $past(nr_r)}; endproperty
   property p_rd_em; CE && RD && ADDR == 8'h4C |=> RDATA == {9'h000, $past(em_r)}; endproperty
   property p_rd_unmapped; CE && RD && !hit_map |=> RDATA == 16'h0000; endproperty
   property p_rd_main;
      CE && RD && ADDR == 8'h60 |=> RDATA == {5'h00, $past(SUMMARY_EMPTY_FLAG), $past(SUMMARY_NOTREADY_FLAG), 9'h000};
   endproperty
   property p_nr_flag;
      CE && !SOFT_RESET |=> SUMMARY_NOTREADY_FLAG == |($past(PIPE_NOTREADY_STATUS) & $past(nr_r));
   endproperty
   property p_em_flag;
      CE && !SOFT_RESET |=> SUMMARY_EMPTY_FLAG == |($past(PIPE_EMPTY_ERR_STATUS) & $past(em_r));
   endproperty
   property p_soft; CE && SOFT_RESET ##1 CE |=> !SUMMARY_NOTREADY_FLAG && !SUMMARY_EMPTY_FLAG; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   a_rd_nr: assert property (p_rd_nr) else $error("not-ready enable readback");
   a_rd_em: assert property (p_rd_em) else $error("empty enable readback");
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
   a_rd_main: assert property (p_rd_main) else $error("main status readback");
   a_nr_flag: assert property (p_nr_flag) else $error("not-ready flag wrong");
   a_em_flag: assert property (p_em_flag) else $error("empty flag wrong");
   a_soft: assert property (p_soft) else $error("flags after soft reset");
   c_nr: cover property ($rose(SUMMARY_NOTREADY_FLAG));
   c_em: cover property ($rose(SUMMARY_EMPTY_FLAG));
   c_irq: cover property ($rose(IRQ));
endmodule : gate_monitor
bind pipe_buffer_irq_enable_gate gate_monitor mon (.CLK(CLK), .RST_B(RST_B), .CE(CE), .SOFT_RESET(SOFT_RESET),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIPE_NOTREADY_STATUS(PIPE_NOTREADY_STATUS),
   .PIPE_EMPTY_ERR_STATUS(PIPE_EMPTY_ERR_STATUS), .SUMMARY_NOTREADY_FLAG(SUMMARY_NOTREADY_FLAG),
   .SUMMARY_EMPTY_FLAG(SUMMARY_EMPTY_FLAG), .IRQ(IRQ));
`default_nettype wire

// ### testbench/pipe_buffer_irq_enable_gate_test.sv
`timescale 1ns/1ns
`default_nettype none
module pipe_buffer_irq_enable_gate_test
   import irq_gate_pkg::*;
;
   logic clk = 1'h0;
   logic rst_b, ce, soft_reset, wr_s, rd_s, nr_flag, em_flag, irq;
   logic [7:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [6:0] ns;
   logic [6:0] es;
   int failures = 0;
   int n_compared = 0;
   always #10 clk = ~clk;
   pipe_buffer_irq_enable_gate pipe_buffer_irq_enable_gate_inst (.CLK(clk), .RST_B(rst_b), .CE(ce),
      .SOFT_RESET(soft_reset), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
      .PIPE_NOTREADY_STATUS(ns), .PIPE_EMPTY_ERR_STATUS(es), .SUMMARY_NOTREADY_FLAG(nr_flag),
      .SUMMARY_EMPTY_FLAG(em_flag), .IRQ(irq));
   // ==========
   // bus tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'h1;
      @(posedge clk);
      wr_s <= 1'h0;
   endtask : reg_write
   task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'h1;
      @(posedge clk);
      rd_s <= 1'h0;
      #1;
      chk(rdata, exp);
   endtask : reg_read
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic finish_test;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   // ==========
   // sequence
   initial begin
      rst_b = 1'h0; ce = 1'h1; soft_reset = 1'h0; wr_s = 1'h0; rd_s = 1'h0;
      addr = 8'h00; wdata = 16'h0000; ns = 7'h00; es = 7'h00;
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      reg_read(NOTREADY_EN_OFFSET, 16'h0000);
      reg_read(EMPTY_ERR_EN_OFFSET, 16'h0000);
      reg_read(8'h10, 16'h0000);
      // reserved bits are written as zero, as software must
      reg_write(NOTREADY_EN_OFFSET, 16'h007F);
      reg_write(EMPTY_ERR_EN_OFFSET, 16'h0055);
      reg_read(NOTREADY_EN_OFFSET, 16'h007F);
      reg_read(EMPTY_ERR_EN_OFFSET, 16'h0055);
      // one enable at a time, status on that pipe or on all others
      for (int i = 0; i < PIPES; i++) begin
         reg_write(NOTREADY_EN_OFFSET, 16'(1 << i));
         reg_write(EMPTY_ERR_EN_OFFSET, 16'(1 << i));
         ns <= 7'(1 << i);
         es <= ~7'(1 << i);
         cyc(2);
         chk({15'h0000, nr_flag}, 16'h0001);
         chk({15'h0000, em_flag}, 16'h0000);
         @(posedge clk);
         ns <= ~7'(1 << i);
         es <= 7'(1 << i);
         cyc(2);
         chk({15'h0000, nr_flag}, 16'h0000);
         chk({15'h0000, em_flag}, 16'h0001);
      end
      reg_read(MAIN_IRQ_STATUS_OFFSET, 16'h0400);
      // only pipe 6 empty status passes its enable here
      reg_read(GATED_VIEW_OFFSET, 16'h4000);
      @(posedge clk);
      ns <= 7'h7F;
      reg_write(MAIN_IRQ_STATUS_OFFSET, 16'h0000);
      reg_read(MAIN_IRQ_STATUS_OFFSET, 16'h0600);
      reg_write(EVENT_STATUS_OFFSET, 16'h0003);
      reg_write(EVENT_MASK_OFFSET, 16'h0003);
      reg_read(EVENT_MASK_OFFSET, 16'h0003);
      reg_read(EVENT_STATUS_OFFSET, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      @(posedge clk);
      ns <= 7'h00;
      cyc(3);
      @(posedge clk);
      ns <= 7'h7F;
      cyc(3);
      chk({15'h0000, irq}, 16'h0001);
      reg_read(EVENT_STATUS_OFFSET, 16'h0001);
      reg_write(EVENT_STATUS_OFFSET, 16'h0001);
      #1;
      chk({15'h0000, irq}, 16'h0000);
      // masked event still latches but stays off the interrupt line
      reg_write(EVENT_MASK_OFFSET, 16'h0000);
      es <= 7'h00;
      cyc(3);
      @(posedge clk);
      es <= 7'h7F;
      cyc(3);
      chk({15'h0000, irq}, 16'h0000);
      reg_read(EVENT_STATUS_OFFSET, 16'h0002);
      @(posedge clk);
      ce <= 1'h0;
      reg_write(NOTREADY_EN_OFFSET, 16'h0001);
      ce <= 1'h1;
      reg_read(NOTREADY_EN_OFFSET, 16'h0040);
      @(posedge clk);
      soft_reset <= 1'h1;
      @(posedge clk);
      soft_reset <= 1'h0;
      reg_read(NOTREADY_EN_OFFSET, 16'h0000);
      reg_read(EMPTY_ERR_EN_OFFSET, 16'h0000);
      chk({14'h0000, nr_flag, em_flag}, 16'h0000);
      reg_write(NOTREADY_EN_OFFSET, 16'h007F);
      rst_b <= 1'h0;
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      reg_read(NOTREADY_EN_OFFSET, 16'h0000);
      finish_test();
   end
   // hang guard, far beyond the hundred-odd cycles the sequence needs
   initial begin
      #100000;
      failures++;
      finish_test();
   end
endmodule : pipe_buffer_irq_enable_gate_test
`default_nettype wire
